// ===== dpio_regs.svh
//------------------------------------------------------------------------
// Purpose: register indices, reset values and field positions of dpio
// Assumes: 32-bit AHB-Lite slave, one register per aligned word
// Notes:   byte address of a register is four times its index
//------------------------------------------------------------------------
`ifndef DPIO_REGS_SVH
`define DPIO_REGS_SVH

// register indices (byte address = index * 4)
`define DPIO_IDX_F_LATCH   12'h440
`define DPIO_IDX_G_LATCH   12'h441
`define DPIO_IDX_F_DIR     12'h444
`define DPIO_IDX_G_DIR     12'h445
`define DPIO_IDX_MUX_STAT  12'h446

// reset value of both direction registers: all pins inputs
`define DPIO_DIR_RESET     8'h00

// field positions in the pin-sharing status register
`define DPIO_STAT_TIM_LSB  0
`define DPIO_STAT_ADC_LSB  8

// lowest first-port pin shared with the second timer
`define DPIO_TIMER_LSB     4

// bus answer constants
`define DPIO_HRESP_OKAY    1'b0
`define DPIO_RDATA_ZERO    32'h0000_0000

`endif

// ===== dpio_pkg.sv
//------------------------------------------------------------------------
// Purpose: types shared by the dual parallel port block
// Assumes: dpio_regs.svh gives the register indices
// Notes:   decode function maps a bus address onto a register select
//------------------------------------------------------------------------
`include "dpio_regs.svh"

package dpio_pkg;

    // register select decoded from the address phase
    typedef enum logic [2:0]
    {
        dpio_sel_none   = 3'b000,
        dpio_sel_f_lat  = 3'b001,
        dpio_sel_g_lat  = 3'b010,
        dpio_sel_f_dir  = 3'b011,
        dpio_sel_g_dir  = 3'b100,
        dpio_sel_stat   = 3'b101
    } dpio_sel_type;

    // bus slave phase
    typedef enum logic [0:0]
    {
        dpio_bus_idle = 1'b0,
        dpio_bus_data = 1'b1
    } dpio_bus_type;

    // drive of one eight-pin port
    typedef struct packed
    {
        logic [7:0] value;  // level driven when enabled
        logic [7:0] oe;     // output enable, high drives
    } dpio_pins_type;

    // whole state of the top module
    typedef struct packed
    {
        dpio_bus_type  bus_state;
        dpio_sel_type  sel;
        logic          write;
        logic [7:0]    latch_f;
        logic [7:0]    latch_g;
        logic [7:0]    dir_f;
        logic [7:0]    dir_g;
        dpio_pins_type pins_f;
        dpio_pins_type pins_g;
        logic [31:0]   hrdata;
        logic          hreadyout;
    } dpio_state_type;

    // word-aligned address decode; upper bits must be zero
    function automatic dpio_sel_type dpio_decode(input logic [31:0] addr);
        dpio_sel_type s;
        s = dpio_sel_none;
        if (addr[31:14] == 18'h0_0000 && addr[1:0] == 2'h0)
        begin
            case (addr[13:2])
                `DPIO_IDX_F_LATCH:  s = dpio_sel_f_lat;
                `DPIO_IDX_G_LATCH:  s = dpio_sel_g_lat;
                `DPIO_IDX_F_DIR:    s = dpio_sel_f_dir;
                `DPIO_IDX_G_DIR:    s = dpio_sel_g_dir;
                `DPIO_IDX_MUX_STAT: s = dpio_sel_stat;
                default:            s = dpio_sel_none;
            endcase
        end
        return s;
    endfunction

endpackage

// ===== dpio_sync.sv
//------------------------------------------------------------------------
// Purpose: two-stage synchroniser for the sixteen port pin levels
// Assumes: pins change asynchronously to hclk
// Notes:   first stage feeds the second stage only
//------------------------------------------------------------------------
`timescale 1ns/1ps

module dpio_sync
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hclk_en,
    input  wire logic [15:0] pin_in,
    output logic      [15:0] pin_sync
);

    // both stages in one state word
    typedef struct packed
    {
        logic [15:0] s1;    // metastability catcher
        logic [15:0] s2;    // settled level
    } dpio_sync_type;

    dpio_sync_type st_reg;  // registered state
    dpio_sync_type st_next; // next state

    //--------------------------------------------------------------------
    // next state
    //--------------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        if (hclk_en)
        begin
            st_next.s1 = pin_in;
            st_next.s2 = st_reg.s1;
        end
    end

    // registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign pin_sync = st_reg.s2;

endmodule

// ===== dpio_pin_mux.sv
//------------------------------------------------------------------------
// Purpose: per-pin drive and read-back selection of one eight-pin port
// Assumes: override comes from an on-chip owner of the pin
// Notes:   purely combinational; the caller registers the drive
//------------------------------------------------------------------------
`timescale 1ns/1ps

module dpio_pin_mux
(
    input  wire logic          [7:0] latch,
    input  wire logic          [7:0] dir,
    input  wire logic          [7:0] ovr_en,
    input  wire logic          [7:0] ovr_val,
    input  wire logic          [7:0] ovr_oe,
    input  wire logic          [7:0] pin_lvl,
    output dpio_pkg::dpio_pins_type  drive,
    output logic               [7:0] read_val
);

    logic [7:0] port_oe;    // enable under port control

    //--------------------------------------------------------------------
    // drive and read selection
    //--------------------------------------------------------------------
    always_comb
    begin
        // port drives latch only where direction is output
        port_oe     = dir & ~ovr_en;
        drive.oe    = port_oe | (ovr_en & ovr_oe);
        drive.value = (port_oe & latch) | (ovr_en & ovr_oe & ovr_val);
        // read: latch for outputs, pin level for inputs
        read_val    = (dir & latch) | (~dir & pin_lvl);
    end

endmodule

// ===== dpio_top.sv
//------------------------------------------------------------------------
// Purpose: two eight-bit parallel ports behind an AHB-Lite slave
// Assumes: timer and converter controls come from logic on hclk
// Notes:   data latches have no reset; direction registers do
//------------------------------------------------------------------------
// Notes on behaviour
// RULE1: first port: eight latch and direction bits
// RULE2: reset keeps first port latch contents
// RULE3: reset keeps second port latch contents
// RULE4: direction one drives latch, zero floats
// RULE5: reset clears first port direction bits
// RULE6: reset clears second port direction bits
// RULE7: first port output pins read latch
// RULE8: first port input pins read pin level
// RULE9: second port reads latch or pin likewise
// RULE10: writes always load latch, inputs unaffected
// RULE11: upper first-port pins serve timer when claimed
// RULE12: selected converter pin forced analog input
// RULE13: unselected second-port pins stay digital
// RULE14: software loads latch before setting output
// RULE15: claimed pin driven by timer alone
//------------------------------------------------------------------------
`timescale 1ns/1ps
`include "dpio_regs.svh"

module dpio_top
(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hclk_en,
    input  wire logic          hsel,
    input  wire logic   [31:0] haddr,
    input  wire logic    [1:0] htrans,
    input  wire logic          hwrite,
    input  wire logic    [2:0] hsize,
    input  wire logic   [31:0] hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic        [31:0] hrdata,
    output logic               hresp,
    input  wire logic    [7:0] port_f_pin_in,
    output dpio_pkg::dpio_pins_type port_f_pins,
    input  wire logic    [7:0] port_g_pin_in,
    output dpio_pkg::dpio_pins_type port_g_pins,
    input  wire logic    [3:0] timer_claim,
    input  wire logic    [3:0] timer_channel_out,
    input  wire logic    [3:0] timer_channel_oe,
    output logic         [3:0] timer_channel_in,
    input  wire logic          converter_select_en,
    input  wire logic    [2:0] converter_select_ch
);

    //--------------------------------------------------------------------
    // declarations
    //--------------------------------------------------------------------
    dpio_pkg::dpio_state_type st_reg;      // registered state
    dpio_pkg::dpio_state_type st_next;     // next state
    logic               [15:0] pin_sync;   // settled pin levels
    logic                [7:0] f_claim;    // first-port pins owned by timer
    logic                [7:0] f_ovr_val;  // timer drive value
    logic                [7:0] f_ovr_oe;   // timer drive enable
    logic                [7:0] adc_mask;   // second-port pin owned by adc
    dpio_pkg::dpio_pins_type   f_drive;    // first-port drive next
    dpio_pkg::dpio_pins_type   g_drive;    // second-port drive next
    logic                [7:0] f_read;     // first-port read value
    logic                [7:0] g_read;     // second-port read value
    logic               [31:0] stat_word;  // pin-sharing status
    logic                      accept;     // address phase taken

    //--------------------------------------------------------------------
    // pin synchronisers and per-port muxes
    //--------------------------------------------------------------------
    dpio_sync u_sync
    (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .hclk_en  (hclk_en),
        .pin_in   ({port_g_pin_in, port_f_pin_in}),
        .pin_sync (pin_sync)
    );

    // timer claims only the upper four first-port pins
    assign f_claim   = {timer_claim, 4'h0};       // [RULE11]
    assign f_ovr_val = {timer_channel_out, 4'h0};
    assign f_ovr_oe  = {timer_channel_oe, 4'h0};

    // one-hot converter selection over the second port
    assign adc_mask  = converter_select_en ?
                       8'(8'h01 << converter_select_ch) : 8'h00; // [RULE12]

    dpio_pin_mux u_mux_f
    (
        .latch    (st_reg.latch_f),
        .dir      (st_reg.dir_f),
        .ovr_en   (f_claim),
        .ovr_val  (f_ovr_val),
        .ovr_oe   (f_ovr_oe),
        .pin_lvl  (pin_sync[7:0]),
        .drive    (f_drive),
        .read_val (f_read)
    );

    // analog selection floats the pin: override with no drive
    dpio_pin_mux u_mux_g
    (
        .latch    (st_reg.latch_g),
        .dir      (st_reg.dir_g),
        .ovr_en   (adc_mask),
        .ovr_val  (8'h00),
        .ovr_oe   (8'h00),
        .pin_lvl  (pin_sync[15:8]),
        .drive    (g_drive),
        .read_val (g_read)
    );

    // status word: which pins other blocks hold
    assign stat_word = {16'h0000, adc_mask, 4'h0, timer_claim};

    // address phase taken only in idle phase with a live transfer
    assign accept = hsel && hready && htrans[1] &&
                    (st_reg.bus_state == dpio_pkg::dpio_bus_idle);

    //--------------------------------------------------------------------
    // next state
    //--------------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        if (hclk_en)
        begin
            case (st_reg.bus_state)
                dpio_pkg::dpio_bus_idle:
                begin
                    // capture address phase, insert one wait state
                    if (accept)
                    begin
                        st_next.sel       = dpio_pkg::dpio_decode(haddr);
                        st_next.write     = hwrite;
                        st_next.bus_state = dpio_pkg::dpio_bus_data;
                        st_next.hreadyout = 1'b0;
                    end
                end
                dpio_pkg::dpio_bus_data:
                begin
                    st_next.hrdata = `DPIO_RDATA_ZERO;
                    if (st_reg.write)
                    begin
                        // latch writes ignore direction
                        case (st_reg.sel)
                            dpio_pkg::dpio_sel_f_lat:
                                st_next.latch_f = hwdata[7:0]; // [RULE10]
                            dpio_pkg::dpio_sel_g_lat:
                                st_next.latch_g = hwdata[7:0]; // [RULE10]
                            dpio_pkg::dpio_sel_f_dir:
                                st_next.dir_f = hwdata[7:0];   // [RULE1]
                            dpio_pkg::dpio_sel_g_dir:
                                st_next.dir_g = hwdata[7:0];
                            default:
                                st_next.write = 1'b1;          // ignored
                        endcase
                    end
                    else
                    begin
                        // read mux; unmapped reads as zero
                        case (st_reg.sel)
                            dpio_pkg::dpio_sel_f_lat:
                                st_next.hrdata[7:0] = f_read;  // [RULE7][RULE8]
                            dpio_pkg::dpio_sel_g_lat:
                                st_next.hrdata[7:0] = g_read;  // [RULE9]
                            dpio_pkg::dpio_sel_f_dir:
                                st_next.hrdata[7:0] = st_reg.dir_f;
                            dpio_pkg::dpio_sel_g_dir:
                                st_next.hrdata[7:0] = st_reg.dir_g;
                            dpio_pkg::dpio_sel_stat:
                                st_next.hrdata = stat_word;
                            default:
                                st_next.hrdata = `DPIO_RDATA_ZERO;
                        endcase
                    end
                    st_next.hreadyout = 1'b1;
                    st_next.bus_state = dpio_pkg::dpio_bus_idle;
                end
                default:
                begin
                    st_next.bus_state = dpio_pkg::dpio_bus_idle;
                    st_next.hreadyout = 1'b1;
                end
            endcase
            // register pin drives from the muxes
            st_next.pins_f = f_drive;  // [RULE4][RULE15]
            st_next.pins_g = g_drive;  // [RULE4][RULE13]
        end
    end

    //--------------------------------------------------------------------
    // registers; data latches deliberately not reset
    //--------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_reg.bus_state <= dpio_pkg::dpio_bus_idle;
            st_reg.sel       <= dpio_pkg::dpio_sel_none;
            st_reg.write     <= 1'b0;
            st_reg.dir_f     <= `DPIO_DIR_RESET;   // [RULE5]
            st_reg.dir_g     <= `DPIO_DIR_RESET;   // [RULE6]
            st_reg.pins_f    <= '0;
            st_reg.pins_g    <= '0;
            st_reg.hrdata    <= `DPIO_RDATA_ZERO;
            st_reg.hreadyout <= 1'b1;
            // latches keep their contents [RULE2][RULE3]
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    //--------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------
    assign hreadyout        = st_reg.hreadyout;
    assign hrdata           = st_reg.hrdata;
    assign hresp            = `DPIO_HRESP_OKAY;
    assign port_f_pins      = st_reg.pins_f;
    assign port_g_pins      = st_reg.pins_g;
    assign timer_channel_in = pin_sync[7:`DPIO_TIMER_LSB];

    //--------------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_accept;
        hclk_en && accept;
    endsequence

    sequence s_read_f;
        hclk_en && st_reg.bus_state == dpio_pkg::dpio_bus_data &&
        !st_reg.write && st_reg.sel == dpio_pkg::dpio_sel_f_lat;
    endsequence

    sequence s_read_g;
        hclk_en && st_reg.bus_state == dpio_pkg::dpio_bus_data &&
        !st_reg.write && st_reg.sel == dpio_pkg::dpio_sel_g_lat;
    endsequence

    sequence s_commit_latch;
        hclk_en && st_reg.bus_state == dpio_pkg::dpio_bus_data &&
        st_reg.write && (st_reg.sel == dpio_pkg::dpio_sel_f_lat ||
                         st_reg.sel == dpio_pkg::dpio_sel_g_lat);
    endsequence

    a_bus_wait_state: assert property
        (s_accept ##1 (!hreadyout && hclk_en) |=> hreadyout)
        else $error("transfer not answered after one wait state");

    a_dir_reset_clear: assert property // [RULE5][RULE6]
        ($rose(hresetn) |-> st_reg.dir_f == 8'h00 && st_reg.dir_g == 8'h00)
        else $error("direction not cleared by reset");

    a_write_latch_f: assert property // [RULE10][RULE1]
        (hclk_en && st_reg.bus_state == dpio_pkg::dpio_bus_data &&
         st_reg.write && st_reg.sel == dpio_pkg::dpio_sel_f_lat
         |=> st_reg.latch_f == $past(hwdata[7:0]))
        else $error("first port latch not loaded by write");

    a_latch_only_write: assert property // [RULE2][RULE3]
        (($changed(st_reg.latch_f) || $changed(st_reg.latch_g))
         |-> $past(hclk_en && st_reg.bus_state == dpio_pkg::dpio_bus_data &&
                   st_reg.write))
        else $error("port latch changed without a write");

    a_read_port_f: assert property // [RULE7][RULE8]
        (s_read_f |=> hreadyout && hrdata[7:0] ==
            (($past(st_reg.dir_f) & $past(st_reg.latch_f)) |
             (~$past(st_reg.dir_f) & $past(pin_sync[7:0]))))
        else $error("first port read value wrong");

    a_read_port_g: assert property // [RULE9]
        (s_read_g |=> hreadyout && hrdata[7:0] ==
            (($past(st_reg.dir_g) & $past(st_reg.latch_g)) |
             (~$past(st_reg.dir_g) & $past(pin_sync[15:8]))))
        else $error("second port read value wrong");

    a_f_drive_owner: assert property // [RULE4][RULE11][RULE15]
        (hclk_en |=> port_f_pins.oe ==
            (($past(st_reg.dir_f) & ~$past(f_claim)) |
             ($past(f_claim) & $past(f_ovr_oe))))
        else $error("first port enable not from owner");

    a_timer_value: assert property // [RULE15]
        (hclk_en |=> ((port_f_pins.value[7:4] ^ $past(timer_channel_out)) &
                      $past(timer_claim & timer_channel_oe)) == 4'h0)
        else $error("claimed pin not driven by timer");

    a_adc_pin_float: assert property // [RULE12]
        (hclk_en && converter_select_en
         |=> !port_g_pins.oe[$past(converter_select_ch)])
        else $error("converter pin still driven");

    a_g_digital_pins: assert property // [RULE13][RULE4]
        (hclk_en |=> ((port_g_pins.oe ^ $past(st_reg.dir_g)) &
                      ~$past(adc_mask)) == 8'h00)
        else $error("digital second port enable wrong");

endmodule

// ===== dpio_pin_model.sv
//------------------------------------------------------------------------
// Purpose: external circuitry on one eight-pin port
// Assumes: pins driven by the block win over the outside driver
// Notes:   a released, undriven line shows the inverse of its last level
//------------------------------------------------------------------------
`timescale 1ns/1ps

module dpio_pin_model
(
    input  wire logic                    hclk,
    input  dpio_pkg::dpio_pins_type      pins,
    input  wire logic              [7:0] ext_val,
    input  wire logic              [7:0] ext_en,
    output logic                   [7:0] lvl
);
    logic [7:0] last_lvl;  // level seen one cycle back

    // remember the wire level so a floating line can wander
    always_ff @(posedge hclk)
    begin
        last_lvl <= lvl;
    end

    // block drive first, then outside drive, else floating
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pins.oe[i])
                lvl[i] = pins.value[i];
            else if (ext_en[i])
                lvl[i] = ext_val[i];
            else
                lvl[i] = ~last_lvl[i];
        end
    end
endmodule

// ===== dual_parallel_io_ports_tb_top.sv
//------------------------------------------------------------------------
// Purpose: self-checking bench of the dual parallel port block
// Assumes: single AHB-Lite master, hready tied to the slave's answer
// Notes:   hsize held constant; hclk_en dropped once to check the freeze
//------------------------------------------------------------------------
`timescale 1ns/1ps
`include "dpio_regs.svh"

module dual_parallel_io_ports_tb_top;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [7:0] f_lvl, g_lvl, f_ext, g_ext;
    logic [3:0] t_claim, t_out, t_oe, t_in;
    logic cv_en, clk_en;
    logic [2:0] cv_ch;
    dpio_pkg::dpio_pins_type f_pins, g_pins;
    int miscompares, n_compared;

    dpio_top dut (.hclk(hclk), .hresetn(hresetn), .hclk_en(clk_en),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .port_f_pin_in(f_lvl), .port_f_pins(f_pins),
        .port_g_pin_in(g_lvl), .port_g_pins(g_pins),
        .timer_claim(t_claim), .timer_channel_out(t_out),
        .timer_channel_oe(t_oe), .timer_channel_in(t_in),
        .converter_select_en(cv_en), .converter_select_ch(cv_ch));
    dpio_pin_model pm_f (.hclk(hclk), .pins(f_pins), .ext_val(f_ext),
        .ext_en(8'hFF), .lvl(f_lvl));
    dpio_pin_model pm_g (.hclk(hclk), .pins(g_pins), .ext_val(g_ext),
        .ext_en(~g_pins.oe), .lvl(g_lvl));

    // 50 MHz clock
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // verdict and end of run
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // compare and count
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // wait for hready high at a rising edge, bounded
    task automatic wait_ready();
        int i;
        i = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            i++;
            if (i > 50)
            begin
                miscompares++;
                end_of_test();
            end
            @(posedge hclk);
        end
    endtask

    // one single AHB-Lite transfer; byte address is four times the index
    task automatic bus(input logic w, input logic [11:0] idx,
                       input logic [7:0] d);
        haddr <= {18'h0_0000, idx, 2'h0};
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        wait_ready();
        rd = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    // reset: directions clear, pins float, unmapped reads zero
    task automatic sc_reset_values();
        bus(1'b0, `DPIO_IDX_F_DIR, 8'h00);
        check("f_dir", rd, 32'h0);
        bus(1'b0, `DPIO_IDX_G_DIR, 8'h00);
        check("g_dir", rd, 32'h0);
        check("pins", {f_pins, g_pins}, 32'h0);
        bus(1'b0, 12'h7FF, 8'h00);
        check("unmapped", rd, 32'h0);
    endtask

    // first port: input reads pin, output drives and reads latch
    task automatic sc_first_port();
        f_ext <= 8'hC3;
        bus(1'b1, `DPIO_IDX_F_LATCH, 8'h5A);
        bus(1'b0, `DPIO_IDX_F_LATCH, 8'h00);
        check("f_in_read", rd, 32'hC3);
        bus(1'b1, `DPIO_IDX_F_DIR, 8'hFF);
        bus(1'b0, `DPIO_IDX_F_DIR, 8'h00);
        check("f_dir_rw", rd, 32'hFF);
        repeat (2) @(posedge hclk);
        check("f_pins", f_pins, 16'h5AFF);
        bus(1'b0, `DPIO_IDX_F_LATCH, 8'h00);
        check("f_out_read", rd, 32'h5A);
    endtask

    // second port: mixed directions with one converter pin
    task automatic sc_second_port();
        g_ext <= 8'h3C;
        cv_ch <= 3'h1;
        cv_en <= 1'b1;
        bus(1'b1, `DPIO_IDX_G_LATCH, 8'hA5);
        bus(1'b1, `DPIO_IDX_G_DIR, 8'h0F);
        repeat (3) @(posedge hclk);
        check("g_pins", g_pins, 16'h050D);
        bus(1'b0, `DPIO_IDX_G_LATCH, 8'h00);
        check("g_read", rd, 32'h35);
        bus(1'b0, `DPIO_IDX_MUX_STAT, 8'h00);
        check("stat_adc", rd, 32'h200);
        cv_en <= 1'b0;
        repeat (2) @(posedge hclk);
        check("g_pins_free", g_pins, 16'h050F);
    endtask

    // timer claims upper first-port pins
    task automatic sc_timer();
        f_ext <= 8'h40;
        t_claim <= 4'h5;
        t_out <= 4'hF;
        t_oe <= 4'h1;
        repeat (4) @(posedge hclk);
        check("f_claimed", f_pins, 16'h1ABF);
        check("timer_in", t_in, 4'h5);
        bus(1'b0, `DPIO_IDX_MUX_STAT, 8'h00);
        check("stat_tim", rd, 32'h5);
        // clock enable low freezes the pin flops
        clk_en <= 1'b0;
        t_claim <= 4'h0;
        repeat (3) @(posedge hclk);
        check("f_frozen", f_pins, 16'h1ABF);
        clk_en <= 1'b1;
        repeat (2) @(posedge hclk);
        check("f_released", f_pins, 16'h5AFF);
    endtask

    // mid-run reset keeps both latches
    task automatic sc_latch_keep();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("pins_rst", {f_pins.oe, g_pins.oe}, 16'h0);
        bus(1'b1, `DPIO_IDX_F_DIR, 8'hFF);
        bus(1'b0, `DPIO_IDX_F_LATCH, 8'h00);
        check("f_kept", rd, 32'h5A);
        bus(1'b1, `DPIO_IDX_G_DIR, 8'hFF);
        bus(1'b0, `DPIO_IDX_G_LATCH, 8'h00);
        check("g_kept", rd, 32'hA5);
    endtask

    // main sequence
    initial
    begin
        miscompares = 0;
        n_compared = 0;
        hresetn = 1'b0;
        clk_en = 1'b1;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        f_ext = 8'h00;
        g_ext = 8'h00;
        t_claim = 4'h0;
        t_out = 4'h0;
        t_oe = 4'h0;
        cv_en = 1'b0;
        cv_ch = 3'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        sc_reset_values();
        sc_first_port();
        sc_second_port();
        sc_timer();
        sc_latch_keep();
        end_of_test();
    end
endmodule
